// File: verilog/cirb_pkg.sv
package cirb_pkg;

  // ----------------------------------------------------------------
  // IO addresses and data width
  // ----------------------------------------------------------------
  localparam int unsigned  IO_AW            = 8;
  localparam int unsigned  IO_DW            = 8;
  localparam logic [7:0]   ADDR_ALU_STATUS  = 8'h00;
  localparam logic [7:0]   ADDR_STACK_TOP   = 8'h02;
  localparam logic [7:0]   ADDR_CLOCK_MODE  = 8'h03;
  localparam logic [7:0]   ADDR_IRQ_ENABLE  = 8'h04;
  localparam logic [7:0]   ADDR_IRQ_PENDING = 8'h05;
  localparam logic [7:0]   ADDR_WIDE_TIMER  = 8'h06;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0]   RST_ALU_STATUS   = 8'h00;
  localparam logic [7:0]   RST_STACK_TOP    = 8'h00;
  localparam logic [7:0]   RST_CLOCK_MODE   = 8'hf6;
  localparam logic [7:0]   RST_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0]   RST_IRQ_PENDING  = 8'h00;
  localparam logic [7:0]   RST_WIDE_TIMER   = 8'h00;
  localparam logic [7:0]   MASK_ALU_STATUS  = 8'h0f;
  localparam logic [7:0]   MASK_IRQ         = 8'h77;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned  FLAG_OV          = 3;
  localparam int unsigned  FLAG_HALF        = 2;
  localparam int unsigned  FLAG_C           = 1;
  localparam int unsigned  FLAG_Z           = 0;
  localparam int unsigned  CM_SEL_HI        = 7;
  localparam int unsigned  CM_SEL_LO        = 5;
  localparam int unsigned  CM_FAST_EN       = 4;
  localparam int unsigned  CM_TYPE          = 3;
  localparam int unsigned  CM_SLOW_EN       = 2;
  localparam int unsigned  CM_WDOG_EN       = 1;
  localparam int unsigned  CM_RST_PIN       = 0;
  localparam int unsigned  TM_SRC_HI        = 7;
  localparam int unsigned  TM_SRC_LO        = 5;
  localparam int unsigned  TM_DIV_HI        = 4;
  localparam int unsigned  TM_DIV_LO        = 3;
  localparam int unsigned  TM_BIT_HI        = 2;
  localparam int unsigned  TM_BIT_LO        = 0;
  localparam int unsigned  TM_BIT_BASE      = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CIRB_OP_NONE, CIRB_OP_ADD, CIRB_OP_ADDC, CIRB_OP_SUB,
    CIRB_OP_SUBC, CIRB_OP_SHL_C, CIRB_OP_SHR_C, CIRB_OP_LOGIC
  } cirb_alu_op_t;

  typedef enum logic [1:0] {
    CIRB_SRC_FAST_RC, CIRB_SRC_SLOW_RC, CIRB_SRC_CRYSTAL, CIRB_SRC_RESERVED
  } cirb_sys_src_t;

  typedef enum logic [2:0] {
    CIRB_TSRC_OFF, CIRB_TSRC_SYSCLK, CIRB_TSRC_RESV, CIRB_TSRC_LINE4_FALL,
    CIRB_TSRC_FAST_RC, CIRB_TSRC_CRYSTAL, CIRB_TSRC_SLOW_RC, CIRB_TSRC_LINE0_FALL
  } cirb_tmr_src_t;

  typedef struct packed {
    cirb_alu_op_t op;
    logic [7:0]   a;
    logic [7:0]   b;
  } cirb_alu_req_t;

  typedef struct packed {
    logic ov;
    logic half;
    logic c;
    logic z;
  } cirb_flags_t;

  typedef struct packed {
    cirb_sys_src_t src;
    logic [6:0]    div;
    logic          fast_osc_en;
    logic          slow_osc_en;
    logic          wdog_en;
    logic          reset_pin_sel;
  } cirb_clk_cfg_t;

  typedef struct packed {
    cirb_tmr_src_t src;
    logic [6:0]    div;
    logic [3:0]    event_bit;
  } cirb_tmr_cfg_t;

endpackage

// File: verilog/cirb_core_io_regs.sv
// How it works
// (RULE_01) Signed overflow sets status bit 3.
// (RULE_02) Nibble carry or borrow sets bit 2.
// (RULE_03) Carry or borrow, and shifts, drive bit 1.
// (RULE_04) Zero result sets bit 0; flags reset clear.
// (RULE_05) Stack index reads current value, writes load.
// (RULE_06) Type 0 system clock decode, default slow RC.
// (RULE_07) Type 1 clock decode, type bit resets zero.
// (RULE_08) Bit 4 enables fast RC, resets one.
// (RULE_09) Bit 2 enables slow RC, also stops watchdog.
// (RULE_10) Bit 1 enables watchdog, resets one.
// (RULE_11) Bit 0 selects shared pin as reset.
// (RULE_12) Enable mask gates each request source.
// (RULE_13) Hardware sets request bits, software clears them.
// (RULE_14) Timer mode bits 7-5 choose timer clock.
// (RULE_15) Timer mode bits 4-3 choose pre-divider.
// (RULE_16) Bits 2-0 pick counter bit 8 to 15.
// (RULE_17) Edge select picks rising or falling transition.
// (RULE_18) Requests latch even while disabled.
// (RULE_19) Reserved bits ignore writes, read zero.
`timescale 1ns/10ps
module cirb_core_io_regs (
  // Clock and reset.
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_n_in,
  // Core IO-space access.
  input  wire logic [cirb_pkg::IO_AW-1:0] io_addr_in,
  input  wire logic                       io_wr_in,
  input  wire logic                       io_rd_in,
  input  wire logic [cirb_pkg::IO_DW-1:0] io_wdata_in,
  output logic      [cirb_pkg::IO_DW-1:0] io_rdata_out,
  // ALU flag update.
  input  wire cirb_pkg::cirb_alu_req_t    alu_req_in,
  input  wire logic                       alu_carry_in,
  output cirb_pkg::cirb_flags_t           flags_out,
  // Stack index load from the core.
  input  wire logic                       stack_load_in,
  input  wire logic [7:0]                 stack_value_in,
  output logic      [7:0]                 stack_top_index_out,
  // Interrupt sources.
  input  wire logic [7:0]                 irq_source_evt_in,
  input  wire logic [15:0]                counter_value_in,
  input  wire logic                       timer_falling_sel_in,
  output logic      [7:0]                 irq_pending_out,
  output logic                            irq_to_core_out,
  // Clock and timer configuration.
  output cirb_pkg::cirb_clk_cfg_t         clk_cfg_out,
  output cirb_pkg::cirb_tmr_cfg_t         tmr_cfg_out
);
  import cirb_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // New flag set for one ALU operation; flags an operation leaves alone keep their value.
  function automatic cirb_flags_t alu_flags(input cirb_alu_req_t req, input logic cin,
                                            input cirb_flags_t old);
    cirb_flags_t f;
    logic [8:0]  wide;
    logic [4:0]  nib;
    logic [7:0]  res;
    logic        k;
    f    = old;
    wide = 9'h000;
    nib  = 5'h00;
    res  = 8'h00;
    k    = ((req.op == CIRB_OP_ADDC) || (req.op == CIRB_OP_SUBC)) ? cin : 1'b0;
    unique case (req.op)
      CIRB_OP_ADD, CIRB_OP_ADDC: begin
        wide   = {1'b0, req.a} + {1'b0, req.b} + {8'h00, k};
        nib    = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, k};
        res    = wide[7:0];
        f.c    = wide[8];  // [RULE_03]
        f.half = nib[4];  // [RULE_02]
        f.ov   = (req.a[7] == req.b[7]) && (res[7] != req.a[7]);  // [RULE_01]
        f.z    = (res == 8'h00);  // [RULE_04]
      end
      CIRB_OP_SUB, CIRB_OP_SUBC: begin
        wide   = {1'b0, req.a} - {1'b0, req.b} - {8'h00, k};
        nib    = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, k};
        res    = wide[7:0];
        f.c    = wide[8];  // [RULE_03]
        f.half = nib[4];  // [RULE_02]
        f.ov   = (req.a[7] != req.b[7]) && (res[7] != req.a[7]);  // [RULE_01]
        f.z    = (res == 8'h00);  // [RULE_04]
      end
      CIRB_OP_SHL_C: begin
        f.c = req.a[7];  // [RULE_03]
      end
      CIRB_OP_SHR_C: begin
        f.c = req.a[0];  // [RULE_03]
      end
      CIRB_OP_LOGIC: begin
        f.z = (req.a == 8'h00);  // [RULE_04]
      end
      CIRB_OP_NONE: begin
        f = old;
      end
    endcase
    return f;
  endfunction

  // Maps a two-bit pre-divider code to its divisor (1, 4, 16, 64).
  function automatic logic [6:0] prediv(input logic [1:0] code);
    logic [6:0] d;
    d = 7'h01 << {code, 1'b0};
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  cirb_flags_t flag_q;
  logic [7:0]  stack_top_index;
  logic [7:0]  clock_mode_control;
  logic [7:0]  irq_enable_mask;
  logic [7:0]  irq_pending_flags;
  logic [7:0]  wide_timer_mode;
  logic        sel_bit_prev;
  logic        sel_bit_now;
  logic        timer_evt;
  logic [7:0]  hw_events;
  logic        wr_flag;
  logic        wr_irq;

  assign wr_flag = io_wr_in && (io_addr_in == ADDR_ALU_STATUS);
  assign wr_irq  = io_wr_in && (io_addr_in == ADDR_IRQ_PENDING);

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------

  // An ALU update in the same cycle as a software write wins, since the instruction result is newer.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      flag_q <= cirb_flags_t'(RST_ALU_STATUS[3:0]);                    // [RULE_04]
    end else if (alu_req_in.op != CIRB_OP_NONE) begin
      flag_q <= alu_flags(alu_req_in, alu_carry_in, flag_q);
    end else if (wr_flag) begin
      flag_q <= cirb_flags_t'(io_wdata_in[3:0] & MASK_ALU_STATUS[3:0]); // [RULE_19]
    end
  end

  // ----------------------------------------------------------------
  // Stack index
  // ----------------------------------------------------------------

  // A core load beats a software write in the same cycle.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stack_top_index <= RST_STACK_TOP;
    end else if (stack_load_in) begin
      stack_top_index <= stack_value_in;
    end else if (io_wr_in && (io_addr_in == ADDR_STACK_TOP)) begin
      stack_top_index <= io_wdata_in;  // [RULE_05]
    end
  end

  // ----------------------------------------------------------------
  // Clock mode and timer mode
  // ----------------------------------------------------------------

  // Both are plain read/write bytes; their meaning is decoded further down.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      clock_mode_control <= RST_CLOCK_MODE;                            // [RULE_06] [RULE_07] [RULE_08]
    end else if (io_wr_in && (io_addr_in == ADDR_CLOCK_MODE)) begin
      clock_mode_control <= io_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wide_timer_mode <= RST_WIDE_TIMER;
    end else if (io_wr_in && (io_addr_in == ADDR_WIDE_TIMER)) begin
      wide_timer_mode <= io_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable and request
  // ----------------------------------------------------------------

  // Reserved positions are masked so they always read back as zero.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_enable_mask <= RST_IRQ_ENABLE;                               // [RULE_12]
    end else if (io_wr_in && (io_addr_in == ADDR_IRQ_ENABLE)) begin
      irq_enable_mask <= io_wdata_in & MASK_IRQ;                       // [RULE_19]
    end
  end

  // Selected counter bit and its previous value, for transition detection.
  assign sel_bit_now = counter_value_in[TM_BIT_BASE + 32'(wide_timer_mode[TM_BIT_HI:TM_BIT_LO])]; // [RULE_16]
  assign timer_evt   = timer_falling_sel_in ? (sel_bit_prev && !sel_bit_now)
                                            : (!sel_bit_prev && sel_bit_now);          // [RULE_17]

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sel_bit_prev <= 1'b0;
    end else begin
      sel_bit_prev <= sel_bit_now;
    end
  end

  // The timer transition feeds request bit 2 beside any external overflow event.
  always_comb begin
    hw_events    = irq_source_evt_in & MASK_IRQ;
    hw_events[2] = irq_source_evt_in[2] | timer_evt;
  end

  // A source event in the same cycle as a software clear survives: the set wins.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_pending_flags <= RST_IRQ_PENDING;
    end else if (wr_irq) begin
      irq_pending_flags <= (io_wdata_in & MASK_IRQ) | hw_events;       // [RULE_13] [RULE_19]
    end else begin
      irq_pending_flags <= irq_pending_flags | hw_events;              // [RULE_13] [RULE_18]
    end
  end

  // Delivery to the core is gated by the enable mask only; pending bits are not.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_to_core_out <= 1'b0;
      irq_pending_out <= RST_IRQ_PENDING;
    end else begin
      irq_to_core_out <= |(irq_pending_flags & irq_enable_mask);       // [RULE_12] [RULE_18]
      irq_pending_out <= irq_pending_flags;
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------

  // Decoded clock selection is registered, so it lags a write by one cycle.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      clk_cfg_out <= '{src: CIRB_SRC_SLOW_RC, div: 7'h01, fast_osc_en: 1'b1,
                       slow_osc_en: 1'b1, wdog_en: 1'b1, reset_pin_sel: 1'b0};
    end else begin
      if (!clock_mode_control[CM_TYPE]) begin
        unique case (clock_mode_control[CM_SEL_HI:CM_SEL_LO])         // [RULE_06]
          3'h0: begin
            clk_cfg_out.src <= CIRB_SRC_FAST_RC;
            clk_cfg_out.div <= 7'h04;
          end
          3'h1: begin
            clk_cfg_out.src <= CIRB_SRC_FAST_RC;
            clk_cfg_out.div <= 7'h02;
          end
          3'h2: begin
            clk_cfg_out.src <= CIRB_SRC_RESERVED;
            clk_cfg_out.div <= 7'h01;
          end
          3'h3: begin
            clk_cfg_out.src <= CIRB_SRC_CRYSTAL;
            clk_cfg_out.div <= 7'h04;
          end
          3'h4: begin
            clk_cfg_out.src <= CIRB_SRC_CRYSTAL;
            clk_cfg_out.div <= 7'h02;
          end
          3'h5: begin
            clk_cfg_out.src <= CIRB_SRC_CRYSTAL;
            clk_cfg_out.div <= 7'h01;
          end
          3'h6: begin
            clk_cfg_out.src <= CIRB_SRC_SLOW_RC;
            clk_cfg_out.div <= 7'h04;
          end
          3'h7: begin
            clk_cfg_out.src <= CIRB_SRC_SLOW_RC;
            clk_cfg_out.div <= 7'h01;
          end
        endcase
      end else begin
        unique case (clock_mode_control[CM_SEL_HI:CM_SEL_LO])         // [RULE_07]
          3'h0: begin
            clk_cfg_out.src <= CIRB_SRC_FAST_RC;
            clk_cfg_out.div <= 7'h10;
          end
          3'h1: begin
            clk_cfg_out.src <= CIRB_SRC_FAST_RC;
            clk_cfg_out.div <= 7'h08;
          end
          3'h2: begin
            clk_cfg_out.src <= CIRB_SRC_SLOW_RC;
            clk_cfg_out.div <= 7'h10;
          end
          3'h3: begin
            clk_cfg_out.src <= CIRB_SRC_FAST_RC;
            clk_cfg_out.div <= 7'h20;
          end
          3'h4: begin
            clk_cfg_out.src <= CIRB_SRC_FAST_RC;
            clk_cfg_out.div <= 7'h40;
          end
          3'h5: begin
            clk_cfg_out.src <= CIRB_SRC_CRYSTAL;
            clk_cfg_out.div <= 7'h08;
          end
          3'h6, 3'h7: begin
            clk_cfg_out.src <= CIRB_SRC_RESERVED;
            clk_cfg_out.div <= 7'h01;
          end
        endcase
      end
      clk_cfg_out.fast_osc_en   <= clock_mode_control[CM_FAST_EN];     // [RULE_08]
      clk_cfg_out.slow_osc_en   <= clock_mode_control[CM_SLOW_EN];     // [RULE_09]
      // The watchdog runs from the slow oscillator, so it cannot run while that is off.
      clk_cfg_out.wdog_en       <= clock_mode_control[CM_WDOG_EN] &
                                   clock_mode_control[CM_SLOW_EN];     // [RULE_09] [RULE_10]
      clk_cfg_out.reset_pin_sel <= clock_mode_control[CM_RST_PIN];     // [RULE_11]
    end
  end

  // Timer source, pre-divider and event bit index.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tmr_cfg_out <= '{src: CIRB_TSRC_OFF, div: 7'h01, event_bit: 4'h8};
    end else begin
      tmr_cfg_out.src       <= cirb_tmr_src_t'(wide_timer_mode[TM_SRC_HI:TM_SRC_LO]);  // [RULE_14]
      tmr_cfg_out.div       <= prediv(wide_timer_mode[TM_DIV_HI:TM_DIV_LO]);          // [RULE_15]
      tmr_cfg_out.event_bit <= 4'(TM_BIT_BASE) + {1'b0, wide_timer_mode[TM_BIT_HI:TM_BIT_LO]}; // [RULE_16]
    end
  end

  // ----------------------------------------------------------------
  // Outputs and read path
  // ----------------------------------------------------------------

  // Read data is registered; unmapped addresses return zero.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      io_rdata_out        <= 8'h00;
      flags_out           <= cirb_flags_t'(RST_ALU_STATUS[3:0]);
      stack_top_index_out <= RST_STACK_TOP;
    end else begin
      flags_out           <= flag_q;
      stack_top_index_out <= stack_top_index;
      if (io_rd_in) begin
        unique case (io_addr_in)
          ADDR_ALU_STATUS:  io_rdata_out <= {4'h0, flag_q};              // [RULE_19]
          ADDR_STACK_TOP:   io_rdata_out <= stack_top_index;             // [RULE_05]
          ADDR_CLOCK_MODE:  io_rdata_out <= clock_mode_control;
          ADDR_IRQ_ENABLE:  io_rdata_out <= irq_enable_mask;
          ADDR_IRQ_PENDING: io_rdata_out <= irq_pending_flags;
          ADDR_WIDE_TIMER:  io_rdata_out <= wide_timer_mode;
          default:          io_rdata_out <= 8'h00;
        endcase
      end
    end
  end

endmodule

// File: sim/cirb_core_io_regs_sva.sv
`timescale 1ns/10ps
module cirb_core_io_regs_sva (
  // Clock and reset.
  input wire logic                    core_clk_in,
  input wire logic                    rst_n_in,
  // Register access.
  input wire logic [7:0]              io_addr_in,
  input wire logic                    io_wr_in,
  input wire logic                    io_rd_in,
  input wire logic [7:0]              io_wdata_in,
  input wire logic [7:0]              io_rdata_out,
  // Flags and stack.
  input wire cirb_pkg::cirb_alu_req_t alu_req_in,
  input wire cirb_pkg::cirb_flags_t   flags_out,
  input wire logic                    stack_load_in,
  input wire logic [7:0]              stack_value_in,
  input wire logic [7:0]              stack_top_index_out,
  // Requests and configuration.
  input wire logic [7:0]              irq_source_evt_in,
  input wire logic [7:0]              irq_pending_out,
  input wire logic                    irq_to_core_out,
  input wire cirb_pkg::cirb_clk_cfg_t clk_cfg_out,
  input wire cirb_pkg::cirb_tmr_cfg_t tmr_cfg_out
);
  import cirb_pkg::*;
  logic cm_wr;
  logic tm_wr;
  // Write strobes for the clock mode and timer mode registers.
  assign cm_wr = io_wr_in && io_addr_in == ADDR_CLOCK_MODE;
  assign tm_wr = io_wr_in && io_addr_in == ADDR_WIDE_TIMER;
  // Reference addition flags.
  function automatic logic [3:0] add_f(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {a[7] == b[7] && s[7] != a[7], {1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0f, s[8], s[7:0] == 8'h00};
  endfunction
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_add_flags;
    alu_req_in.op == CIRB_OP_ADD ##1 alu_req_in.op == CIRB_OP_NONE && !io_wr_in
      |-> ##1 flags_out == add_f($past(alu_req_in.a, 2), $past(alu_req_in.b, 2));
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("addition flags differ");
  property p_stack_load;
    stack_load_in ##1 !stack_load_in && !io_wr_in |-> ##1 stack_top_index_out == $past(stack_value_in, 2);
  endproperty
  a_stack_load: assert property (p_stack_load) else $error("stack load lost");
  property p_irq_set;
    (irq_source_evt_in & MASK_IRQ) != 8'h00
      |-> ##2 (irq_pending_out & $past(irq_source_evt_in, 2) & MASK_IRQ) == ($past(irq_source_evt_in, 2) & MASK_IRQ);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("request not latched");
  property p_irq_quiet;
    irq_pending_out == 8'h00 |-> !irq_to_core_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without request");
  property p_reserved;
    (irq_pending_out & 8'h88) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved request bit set");
  property p_wdog;
    clk_cfg_out.wdog_en |-> clk_cfg_out.slow_osc_en;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog runs without slow oscillator");
  property p_clk_bits;
    cm_wr ##1 !cm_wr |-> ##1 clk_cfg_out.fast_osc_en == $past(io_wdata_in[4], 2)
      && clk_cfg_out.reset_pin_sel == $past(io_wdata_in[0], 2);
  endproperty
  a_clk_bits: assert property (p_clk_bits) else $error("clock enable bits differ");
  property p_clk_crystal;
    cm_wr && {io_wdata_in[7:5], io_wdata_in[3]} == 4'b1010 ##1 !cm_wr
      |-> ##1 clk_cfg_out.src == CIRB_SRC_CRYSTAL && clk_cfg_out.div == 7'h01;
  endproperty
  a_clk_crystal: assert property (p_clk_crystal) else $error("type 0 crystal decode wrong");
  property p_clk_t1;
    cm_wr && {io_wdata_in[7:5], io_wdata_in[3]} == 4'b1001 ##1 !cm_wr
      |-> ##1 clk_cfg_out.src == CIRB_SRC_FAST_RC && clk_cfg_out.div == 7'h40;
  endproperty
  a_clk_t1: assert property (p_clk_t1) else $error("type 1 decode wrong");
  property p_tmr;
    tm_wr ##1 !tm_wr |-> ##1 tmr_cfg_out.event_bit == 4'h8 + $past(io_wdata_in[2:0], 2)
      && tmr_cfg_out.src == $past(io_wdata_in[7:5], 2);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer mode decode wrong");
  property p_tdiv;
    tm_wr && io_wdata_in[4:3] == 2'b11 ##1 !tm_wr |-> ##1 tmr_cfg_out.div == 7'h40;
  endproperty
  a_tdiv: assert property (p_tdiv) else $error("timer divider wrong");
  property p_unmapped;
    io_rd_in && io_addr_in == 8'h01 |=> io_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind cirb_core_io_regs cirb_core_io_regs_sva chk (.*);

// File: sim/core_io_register_bank_bench.sv
`timescale 1ns/10ps
module core_io_register_bank_bench;
  import cirb_pkg::*;
  logic          core_clk_in, rst_n_in, io_wr_in, io_rd_in, alu_carry_in;
  logic          stack_load_in, timer_falling_sel_in, irq_to_core_out;
  logic [7:0]    io_addr_in, io_wdata_in, io_rdata_out, stack_value_in, stack_top_index_out;
  logic [7:0]    irq_source_evt_in, irq_pending_out, rd;
  logic [15:0]   counter_value_in;
  cirb_alu_req_t alu_req_in;
  cirb_flags_t   flags_out;
  cirb_clk_cfg_t clk_cfg_out;
  cirb_tmr_cfg_t tmr_cfg_out;
  int            fails = 0, comparisons = 0, cyc = 0;
  // Clock divisor and source per code, type 0 then 1.
  int            dv[16] = '{4, 2, 1, 4, 2, 1, 4, 1, 16, 8, 16, 32, 64, 8, 1, 1};
  int            sv[16] = '{0, 0, 3, 2, 2, 2, 1, 1, 0, 0, 1, 0, 0, 2, 3, 3};

  cirb_core_io_regs uut (.*);

  // Free-running system clock.
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang still reaches the verdict; tests need a few hundred cycles.
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      tally_and_finish;
    end
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write pulse, then a spare edge for decoded outputs.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    io_wr_in <= 1'b1;
    io_addr_in <= a;
    io_wdata_in <= d;
    @(posedge core_clk_in);
    io_wr_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk_in);
    io_rd_in <= 1'b1;
    io_addr_in <= a;
    @(posedge core_clk_in);
    io_rd_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    rd = io_rdata_out;
  endtask

  task automatic do_reset;
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rdr(8'(i));
      cmp("reset read", (i == 3) ? 16'h00f6 : 16'h0000, 16'(rd));
    end
    cmp("clk cfg", 16'h081e, 16'(clk_cfg_out));
    cmp("tmr cfg", 16'h0018, 16'(tmr_cfg_out));
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(ADDR_ALU_STATUS, 8'hff);
    rdr(ADDR_ALU_STATUS);
    cmp("status", 16'h000f, 16'(rd));
    cmp("flags", 16'h000f, 16'(flags_out));
    wr(ADDR_ALU_STATUS, 8'h00);
    wr(ADDR_STACK_TOP, 8'ha5);
    rdr(ADDR_STACK_TOP);
    cmp("stack", 16'h00a5, 16'(rd));
    @(posedge core_clk_in);
    stack_load_in <= 1'b1;
    stack_value_in <= 8'h3c;
    @(posedge core_clk_in);
    stack_load_in <= 1'b0;
    rdr(ADDR_STACK_TOP);
    cmp("stack", 16'h003c, 16'(rd));
    cmp("stack out", 16'h003c, 16'(stack_top_index_out));
    wr(ADDR_IRQ_ENABLE, 8'hff);
    rdr(ADDR_IRQ_ENABLE);
    cmp("enable", 16'h0077, 16'(rd));
    wr(ADDR_IRQ_ENABLE, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_clk;
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {i[2:0], i[0], i[3], i[1], i[2] ^ i[0], i[1] ^ i[2]};
      wr(ADDR_CLOCK_MODE, v);
      cmp("clk cfg", {3'h0, sv[i][1:0], dv[i][6:0], v[4], v[2], v[1] & v[2], v[0]}, 16'(clk_cfg_out));
      rdr(ADDR_CLOCK_MODE);
      cmp("clock mode", 16'(v), 16'(rd));
    end
    wr(ADDR_CLOCK_MODE, 8'hf6);
    $display("test clock mode done");
  endtask

  task automatic t_tmr;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], i[1:0], 3'(7 - i)};
      wr(ADDR_WIDE_TIMER, v);
      cmp("tmr cfg", {2'h0, i[2:0], 7'(1 << (2 * i[1:0])), 4'(15 - i)}, 16'(tmr_cfg_out));
      rdr(ADDR_WIDE_TIMER);
      cmp("timer mode", 16'(v), 16'(rd));
    end
    $display("test timer mode done");
  endtask

  task automatic alu(input cirb_alu_op_t op, input logic [7:0] a, input logic [7:0] b, input logic cy,
                     input logic [3:0] exp);
    @(posedge core_clk_in);
    alu_req_in <= '{op, a, b};
    alu_carry_in <= cy;
    @(posedge core_clk_in);
    alu_req_in <= '{CIRB_OP_NONE, 8'h00, 8'h00};
    @(posedge core_clk_in);
    #1;
    cmp("flags", 16'(exp), 16'(flags_out));
  endtask

  task automatic t_alu;
    alu(CIRB_OP_ADD, 8'h7f, 8'h01, 1'b0, 4'b1100);
    alu(CIRB_OP_ADD, 8'hff, 8'h01, 1'b0, 4'b0111);
    alu(CIRB_OP_ADDC, 8'h0e, 8'h01, 1'b1, 4'b0100);
    alu(CIRB_OP_SUB, 8'h00, 8'h01, 1'b0, 4'b0110);
    alu(CIRB_OP_SUB, 8'h80, 8'h01, 1'b0, 4'b1100);
    alu(CIRB_OP_SHL_C, 8'h80, 8'h00, 1'b0, 4'b1110);
    alu(CIRB_OP_SHR_C, 8'h02, 8'h00, 1'b0, 4'b1100);
    alu(CIRB_OP_LOGIC, 8'h00, 8'h00, 1'b0, 4'b1101);
    alu(CIRB_OP_LOGIC, 8'h01, 8'h00, 1'b0, 4'b1100);
    alu(CIRB_OP_SUBC, 8'h10, 8'h01, 1'b1, 4'b0100);
    $display("test flags done");
  endtask

  // One counter step, then wait for the pending output.
  task automatic cnt(input logic [15:0] v, input logic fall, input logic [7:0] exp);
    @(posedge core_clk_in);
    counter_value_in <= v;
    timer_falling_sel_in <= fall;
    repeat (3) @(posedge core_clk_in);
    #1;
    cmp("pending", 16'(exp), 16'(irq_pending_out));
  endtask

  task automatic t_irq;
    @(posedge core_clk_in);
    irq_source_evt_in <= 8'hff;
    @(posedge core_clk_in);
    irq_source_evt_in <= 8'h00;
    rdr(ADDR_IRQ_PENDING);
    cmp("pending", 16'h0077, 16'(rd));
    cmp("irq", 16'h0000, 16'(irq_to_core_out));
    wr(ADDR_IRQ_ENABLE, 8'h20);
    cmp("irq", 16'h0001, 16'(irq_to_core_out));
    wr(ADDR_IRQ_PENDING, 8'h00);
    cmp("pending", 16'h0000, 16'(irq_pending_out));
    cmp("irq", 16'h0000, 16'(irq_to_core_out));
    wr(ADDR_WIDE_TIMER, 8'h01);
    cnt(16'h0100, 1'b0, 8'h00);
    cnt(16'h0300, 1'b0, 8'h04);
    wr(ADDR_IRQ_PENDING, 8'h00);
    cnt(16'h0000, 1'b0, 8'h00);
    cnt(16'h0200, 1'b1, 8'h00);
    cnt(16'h0000, 1'b1, 8'h04);
    $display("test requests done");
  endtask

  // Main sequence; the second reset lands mid-run.
  initial begin
    rst_n_in = 1'b0;
    {io_wr_in, io_rd_in, alu_carry_in, stack_load_in, timer_falling_sel_in} = '0;
    {io_addr_in, io_wdata_in, stack_value_in, irq_source_evt_in} = '0;
    counter_value_in = '0;
    alu_req_in = '0;
    do_reset;
    t_reset;
    t_regs;
    t_clk;
    t_tmr;
    t_alu;
    t_irq;
    do_reset;
    t_reset;
    tally_and_finish;
  end
endmodule
